// ==== hw/psrc_defines.svh ====
// register offsets, field positions and reset values of the soft reset control block
// assumes it is included by bare name from every design file that needs it
`ifndef PSRC_DEFINES_SVH
`define PSRC_DEFINES_SVH

// register byte offsets
`define PSRC_OFS_RESET_A       12'h040
`define PSRC_OFS_RESET_B       12'h044
`define PSRC_OFS_STATE_A       12'h050
`define PSRC_OFS_STATE_B       12'h054

// reset values
`define PSRC_RESET_VALUE       32'h00000000
`define PSRC_OUT_RESET_VALUE   32'hFFFFFFFF

// first register fields
`define PSRC_A_CAN_ONE         25
`define PSRC_A_CAN_ZERO        24
`define PSRC_A_PWM             20
`define PSRC_A_SLEEP_POWER     6
`define PSRC_A_WATCHDOG        3

// second register fields
`define PSRC_B_COMP_TWO        26
`define PSRC_B_COMP_ONE        25
`define PSRC_B_COMP_ZERO       24
`define PSRC_B_TIMER_THREE     19
`define PSRC_B_TIMER_TWO       18
`define PSRC_B_TIMER_ONE       17
`define PSRC_B_TIMER_ZERO      16
`define PSRC_B_TWO_WIRE        12
`define PSRC_B_QUADRATURE      8
`define PSRC_B_SYNC_SERIAL     4
`define PSRC_B_ASYNC_SERIAL    0

// bits that exist at all; every other position reads zero
`define PSRC_IMPL_A            32'h03100048
`define PSRC_IMPL_B            32'h070F1111

// bus responses
`define PSRC_RESP_OKAY         2'h0
`define PSRC_RESP_SLVERR       2'h2

`endif

// ==== hw/psrc_pkg.sv ====
// types shared by the soft reset control block
// assumes psrc_defines.svh holds all numeric constants
package psrc_pkg;

    // register selected by a bus address
    typedef enum logic [2:0] {
        SEL_NONE    = 3'b000,
        SEL_RESET_A = 3'b001,
        SEL_RESET_B = 3'b010,
        SEL_STATE_A = 3'b011,
        SEL_STATE_B = 3'b100
    } psrc_sel_type;

endpackage

// ==== hw/psrc_reset_drive.sv ====
// registered reset drive for a group of peripherals
// assumes ctrl comes from software-written control bits in the same clock domain
`timescale 1ns/1ps
`include "psrc_defines.svh"
module psrc_reset_drive #(
    parameter int W = 32
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // control bits
    input  wire logic [W-1:0] ctrl,
    // peripheral resets, high holds the unit in reset
    output logic      [W-1:0] periphRst
);

    // refuse widths that a register word cannot feed
    if (W < 1 || W > 32) begin : g_bad_width
        $error("psrc_reset_drive: W must be 1 to 32");
    end

    // peripherals stay in reset while the system reset is applied
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            periphRst <= W'(`PSRC_OUT_RESET_VALUE);
        end else begin
            periphRst <= ctrl;
        end
    end

endmodule

// ==== hw/psrc_top.sv ====
// What this block does
// - Written bits take effect only where the capability mask marks the unit present.
// - Both reset control registers reset to all zeros.
// - First register: bit 25 CAN one, bit 24 CAN zero, bit 20 PWM.
// - First register: bit 6 sleep power unit, bit 3 watchdog.
// - Second register: bits 26, 25, 24 reset comparators two, one, zero.
// - Second register: bits 19 down to 16 reset timers three down to zero.
// - Second register: bit 12 resets two-wire serial unit zero.
// - Second register: bit 8 quadrature, bit 4 sync serial, bit 0 UART.
// - Unassigned bits read zero and ignore writes.
//
// peripheral soft reset control registers behind an AXI4-Lite slave
// assumes capability masks are static levels from the capability registers
`timescale 1ns/1ps
`include "psrc_defines.svh"
module psrc_top #(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rst,
    // write address channel
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // write data channel
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // write response channel
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // read address channel
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // read data channel
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // capability masks
    input  wire logic [31:0]       capabilityMaskOne,
    input  wire logic [31:0]       capabilityMaskTwo,
    // peripheral resets from the first register
    output logic                   canUnitOneReset,
    output logic                   canUnitZeroReset,
    output logic                   pwmReset,
    output logic                   sleepPowerUnitReset,
    output logic                   watchdogReset,
    // peripheral resets from the second register
    output logic                   comparatorTwoReset,
    output logic                   comparatorOneReset,
    output logic                   comparatorZeroReset,
    output logic                   timerThreeReset,
    output logic                   timerTwoReset,
    output logic                   timerOneReset,
    output logic                   timerZeroReset,
    output logic                   twoWireZeroReset,
    output logic                   quadratureZeroReset,
    output logic                   syncSerialZeroReset,
    output logic                   asyncSerialZeroReset
);

    // refuse address widths that cannot reach every offset
    if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr_w
        $error("psrc_top: ADDR_W must be 7 to 32");
    end

    // address decode on the word address
    function automatic psrc_pkg::psrc_sel_type decodeAddr(input logic [ADDR_W-1:0] addr);
        logic [11:0] ofs;
        ofs = 12'(addr);
        if (ADDR_W > 12 && (addr >> 12) != '0) begin
            return psrc_pkg::SEL_NONE;
        end
        unique case ({ofs[11:2], 2'b00})
            `PSRC_OFS_RESET_A: return psrc_pkg::SEL_RESET_A;
            `PSRC_OFS_RESET_B: return psrc_pkg::SEL_RESET_B;
            `PSRC_OFS_STATE_A: return psrc_pkg::SEL_STATE_A;
            `PSRC_OFS_STATE_B: return psrc_pkg::SEL_STATE_B;
            default:           return psrc_pkg::SEL_NONE;
        endcase
    endfunction

    // byte strobes widened to a bit mask
    function automatic logic [31:0] strobeMask(input logic [3:0] strb);
        logic [31:0] m;
        m = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            m[i*8 +: 8] = {8{strb[i]}};
        end
        return m;
    endfunction

    // masked merge of a write into a control register
    function automatic logic [31:0] mergeWrite(input logic [31:0] old, input logic [31:0] data,
                                               input logic [31:0] writable);
        return (old & ~writable) | (data & writable);
    endfunction

    // write channel holding state
    logic [ADDR_W-1:0] awAddr_r;
    logic              awHeld_r;
    logic              awHeld_nxt;
    logic [31:0]       wData_r;
    logic [3:0]        wStrb_r;
    logic              wHeld_r;
    logic              wHeld_nxt;
    logic              awReady_r;
    logic              wReady_r;
    logic              bValid_r;
    logic              bValid_nxt;
    logic [1:0]        bResp_r;
    logic              awTaken;
    logic              wTaken;
    logic              doWrite;
    psrc_pkg::psrc_sel_type wrSel;

    // read channel state
    logic              arReady_r;
    logic              rValid_r;
    logic              rValid_nxt;
    logic [31:0]       rData_r;
    logic [1:0]        rResp_r;
    logic              arTaken;
    psrc_pkg::psrc_sel_type rdSel;

    // control registers and driven resets
    logic [31:0]       resetA_r;
    logic [31:0]       resetB_r;
    logic [31:0]       driveA;
    logic [31:0]       driveB;
    logic [31:0]       writableA;
    logic [31:0]       writableB;

    assign awTaken    = s_axi_awvalid & awReady_r;
    assign wTaken     = s_axi_wvalid & wReady_r;
    assign doWrite    = awHeld_r & wHeld_r & ~bValid_r;
    assign awHeld_nxt = (awHeld_r | awTaken) & ~doWrite;
    assign wHeld_nxt  = (wHeld_r | wTaken) & ~doWrite;
    assign bValid_nxt = doWrite | (bValid_r & ~s_axi_bready);
    assign wrSel      = decodeAddr(awAddr_r);

    assign arTaken    = s_axi_arvalid & arReady_r;
    assign rValid_nxt = arTaken | (rValid_r & ~s_axi_rready);
    assign rdSel      = decodeAddr(s_axi_araddr);

    // only present, assigned and strobed bits can change
    assign writableA = strobeMask(wStrb_r) & `PSRC_IMPL_A & capabilityMaskOne;
    assign writableB = strobeMask(wStrb_r) & `PSRC_IMPL_B & capabilityMaskTwo;

    // write address capture
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            awAddr_r  <= '0;
            awHeld_r  <= 1'b0;
            awReady_r <= 1'b0;
        end else begin
            if (awTaken) begin
                awAddr_r <= s_axi_awaddr;
            end
            awHeld_r  <= awHeld_nxt;
            awReady_r <= ~awHeld_nxt;
        end
    end

    // write data capture
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wData_r  <= 32'h00000000;
            wStrb_r  <= 4'h0;
            wHeld_r  <= 1'b0;
            wReady_r <= 1'b0;
        end else begin
            if (wTaken) begin
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            wHeld_r  <= wHeld_nxt;
            wReady_r <= ~wHeld_nxt;
        end
    end

    // write response
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bValid_r <= 1'b0;
            bResp_r  <= `PSRC_RESP_OKAY;
        end else begin
            bValid_r <= bValid_nxt;
            if (doWrite) begin
                bResp_r <= (wrSel == psrc_pkg::SEL_RESET_A || wrSel == psrc_pkg::SEL_RESET_B)
                           ? `PSRC_RESP_OKAY : `PSRC_RESP_SLVERR;
            end
        end
    end

    // first control register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resetA_r <= `PSRC_RESET_VALUE;
        end else if (doWrite && wrSel == psrc_pkg::SEL_RESET_A) begin
            resetA_r <= mergeWrite(resetA_r, wData_r, writableA);
        end
    end

    // second control register
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            resetB_r <= `PSRC_RESET_VALUE;
        end else if (doWrite && wrSel == psrc_pkg::SEL_RESET_B) begin
            resetB_r <= mergeWrite(resetB_r, wData_r, writableB);
        end
    end

    // read channel
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            arReady_r <= 1'b0;
            rValid_r  <= 1'b0;
            rData_r   <= 32'h00000000;
            rResp_r   <= `PSRC_RESP_OKAY;
        end else begin
            arReady_r <= ~rValid_nxt;
            rValid_r  <= rValid_nxt;
            if (arTaken) begin
                rResp_r <= `PSRC_RESP_OKAY;
                unique case (rdSel)
                    psrc_pkg::SEL_RESET_A: rData_r <= resetA_r & `PSRC_IMPL_A;
                    psrc_pkg::SEL_RESET_B: rData_r <= resetB_r & `PSRC_IMPL_B;
                    psrc_pkg::SEL_STATE_A: rData_r <= driveA & `PSRC_IMPL_A;
                    psrc_pkg::SEL_STATE_B: rData_r <= driveB & `PSRC_IMPL_B;
                    psrc_pkg::SEL_NONE: begin
                        rData_r <= 32'h00000000;
                        rResp_r <= `PSRC_RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // registered peripheral reset drives
    psrc_reset_drive #(
        .W(32)
    ) u_drive_a (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ctrl      (resetA_r & `PSRC_IMPL_A),
        .periphRst (driveA)
    );

    psrc_reset_drive #(
        .W(32)
    ) u_drive_b (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .ctrl      (resetB_r & `PSRC_IMPL_B),
        .periphRst (driveB)
    );

    // bus outputs
    assign s_axi_awready = awReady_r;
    assign s_axi_wready  = wReady_r;
    assign s_axi_bvalid  = bValid_r;
    assign s_axi_bresp   = bResp_r;
    assign s_axi_arready = arReady_r;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rdata   = rData_r;
    assign s_axi_rresp   = rResp_r;

    // first register peripherals
    assign canUnitOneReset      = driveA[`PSRC_A_CAN_ONE];
    assign canUnitZeroReset     = driveA[`PSRC_A_CAN_ZERO];
    assign pwmReset             = driveA[`PSRC_A_PWM];
    assign sleepPowerUnitReset  = driveA[`PSRC_A_SLEEP_POWER];
    assign watchdogReset        = driveA[`PSRC_A_WATCHDOG];

    // second register peripherals
    assign comparatorTwoReset   = driveB[`PSRC_B_COMP_TWO];
    assign comparatorOneReset   = driveB[`PSRC_B_COMP_ONE];
    assign comparatorZeroReset  = driveB[`PSRC_B_COMP_ZERO];
    assign timerThreeReset      = driveB[`PSRC_B_TIMER_THREE];
    assign timerTwoReset        = driveB[`PSRC_B_TIMER_TWO];
    assign timerOneReset        = driveB[`PSRC_B_TIMER_ONE];
    assign timerZeroReset       = driveB[`PSRC_B_TIMER_ZERO];
    assign twoWireZeroReset     = driveB[`PSRC_B_TWO_WIRE];
    assign quadratureZeroReset  = driveB[`PSRC_B_QUADRATURE];
    assign syncSerialZeroReset  = driveB[`PSRC_B_SYNC_SERIAL];
    assign asyncSerialZeroReset = driveB[`PSRC_B_ASYNC_SERIAL];

endmodule

// ==== verif/psrc_top_properties.sv ====
// bus timing and reset output checks for the soft reset control block
// assumes it is bound to psrc_top and sees only its ports
`timescale 1ns/1ps
`include "psrc_defines.svh"
module psrc_top_properties #(
    parameter int ADDR_W = 12
) (
    input wire logic              sys_clk,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [1:0]        s_axi_bresp,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_rready,
    input wire logic [31:0]       capabilityMaskOne,
    input wire logic [31:0]       capabilityMaskTwo,
    input wire logic              watchdogReset,
    input wire logic              timerZeroReset
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic wrBoth;
    logic wrMapped;
    // write taken on both channels with no response pending
    assign wrBoth = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    assign wrMapped = (s_axi_awaddr == `PSRC_OFS_RESET_A) || (s_axi_awaddr == `PSRC_OFS_RESET_B);

    wr_resp_timing_a: assert property (wrBoth |-> ##2 s_axi_bvalid &&
        s_axi_bresp == ($past(wrMapped, 2) ? `PSRC_RESP_OKAY : `PSRC_RESP_SLVERR))
        else $error("write response late or wrong");
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    rd_resp_timing_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    arready_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    reserved_zero_a: assert property (s_axi_rvalid |-> (s_axi_rdata & ~(`PSRC_IMPL_A | `PSRC_IMPL_B)) == 32'h0)
        else $error("reserved bit read nonzero");
    slverr_data_a: assert property (s_axi_rvalid && s_axi_rresp == `PSRC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("refused read carries data");
    wdog_rise_a: assert property ($rose(watchdogReset) |-> $past(s_axi_bvalid) && $past(capabilityMaskOne[3]))
        else $error("watchdog reset raised without a permitted write");
    timer_rise_a: assert property ($rose(timerZeroReset) |-> $past(s_axi_bvalid) && $past(capabilityMaskTwo[16]))
        else $error("timer reset raised without a permitted write");

    cover property (wrBoth ##2 s_axi_bresp == `PSRC_RESP_SLVERR);
    cover property ($rose(watchdogReset));
    cover property (s_axi_rvalid && s_axi_rresp == `PSRC_RESP_SLVERR);
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the soft reset control block
// assumes psrc_top and its checker are compiled alongside
`timescale 1ns/1ps
`include "psrc_defines.svh"
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin err_total++; \
    $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module tb;
    logic        sys_clk = 1'b0, rst = 1'b1;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, capabilityMaskOne = 32'hFFFFFFFF, capabilityMaskTwo = 32'hFFFFFFFF;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, seenA, seenB, expA, expB, lastRd;
    logic        canUnitOneReset, canUnitZeroReset, pwmReset, sleepPowerUnitReset, watchdogReset;
    logic        comparatorTwoReset, comparatorOneReset, comparatorZeroReset, twoWireZeroReset;
    logic        timerThreeReset, timerTwoReset, timerOneReset, timerZeroReset;
    logic        quadratureZeroReset, syncSerialZeroReset, asyncSerialZeroReset;
    logic [11:0] adr [6] = '{`PSRC_OFS_RESET_A, `PSRC_OFS_RESET_B, `PSRC_OFS_STATE_A,
                             `PSRC_OFS_STATE_B, 12'h060, 12'hFFC};
    int          err_total = 0, checks = 0, cyc = 0;

    psrc_top #(.ADDR_W(12)) u_psrc_top (.*);

    always #2 sys_clk = ~sys_clk;
    // driven resets gathered back into register bit positions
    assign seenA = {6'h0, canUnitOneReset, canUnitZeroReset, 3'h0, pwmReset, 13'h0,
                    sleepPowerUnitReset, 2'h0, watchdogReset, 3'h0};
    assign seenB = {5'h0, comparatorTwoReset, comparatorOneReset, comparatorZeroReset, 4'h0,
                    timerThreeReset, timerTwoReset, timerOneReset, timerZeroReset, 3'h0,
                    twoWireZeroReset, 3'h0, quadratureZeroReset, 3'h0, syncSerialZeroReset,
                    3'h0, asyncSerialZeroReset};

    function automatic logic [1:0] model_wr(logic [11:0] a, logic [31:0] d, logic [3:0] s);
        logic [31:0] m;
        m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        if (a == `PSRC_OFS_RESET_A) begin
            m = m & `PSRC_IMPL_A & capabilityMaskOne;
            expA = (expA & ~m) | (d & m);
            return `PSRC_RESP_OKAY;
        end
        if (a == `PSRC_OFS_RESET_B) begin
            m = m & `PSRC_IMPL_B & capabilityMaskTwo;
            expB = (expB & ~m) | (d & m);
            return `PSRC_RESP_OKAY;
        end
        return `PSRC_RESP_SLVERR;
    endfunction

    // address bits 1:0 do not select a register
    function automatic logic [31:0] exp_rd(logic [11:0] a);
        logic [11:0] w;
        w = {a[11:2], 2'b00};
        if (w == `PSRC_OFS_RESET_A || w == `PSRC_OFS_STATE_A) return expA;
        if (w == `PSRC_OFS_RESET_B || w == `PSRC_OFS_STATE_B) return expB;
        return 32'h0;
    endfunction

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [1:0] er;
        @(posedge sys_clk);
        er = model_wr(a, d, s);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (1) begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        `CHK("bresp", er, s_axi_bresp)
    endtask

    task automatic rd(input logic [11:0] a);
        logic [1:0] er;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (1) begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        lastRd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        er = (exp_rd(a) === 32'h0 && a > `PSRC_OFS_STATE_B) ? `PSRC_RESP_SLVERR : `PSRC_RESP_OKAY;
        `CHK("rresp", er, s_axi_rresp)
        `CHK("rdata", exp_rd(a), s_axi_rdata)
    endtask

    task automatic chk_out();
        `CHK("outA", expA, seenA)
        `CHK("outB", expB, seenB)
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        `CHK("rstA", `PSRC_IMPL_A, seenA)
        `CHK("rstB", `PSRC_IMPL_B, seenB)
        rst <= 1'b0;
        expA = 32'h0;
        expB = 32'h0;
        rd(`PSRC_OFS_RESET_A);
        rd(`PSRC_OFS_RESET_B);
        chk_out();
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end

    initial begin
        void'($urandom(32'h1A84));
        do_reset();
        $display("test reset done");
        // one bit at a time, reserved positions included
        for (int i = 0; i < 32; i++) begin
            wr(`PSRC_OFS_RESET_A, 32'h1 << i, 4'hF);
            rd(`PSRC_OFS_RESET_A);
            wr(`PSRC_OFS_RESET_B, 32'h1 << i, 4'hF);
            rd(`PSRC_OFS_STATE_B);
            chk_out();
        end
        $display("test field map done");
        for (int i = 0; i < 60; i++) begin
            capabilityMaskOne <= $urandom;
            capabilityMaskTwo <= $urandom;
            wr(adr[$urandom_range(5)], $urandom, 4'($urandom));
            rd(adr[$urandom_range(5)]);
            chk_out();
        end
        $display("test random masked writes done");
        // software update by read-modify-write, unaligned read address included
        capabilityMaskOne <= 32'hFFFFFFFF;
        capabilityMaskTwo <= 32'hFFFFFFFF;
        rd(`PSRC_OFS_RESET_B | 12'h003);
        wr(`PSRC_OFS_RESET_B, lastRd | (32'h1 << `PSRC_B_TIMER_ZERO), 4'hF);
        rd(`PSRC_OFS_RESET_B);
        chk_out();
        $display("test read-modify-write done");
        do_reset();
        $display("test mid-run reset done");
        complete_run();
    end
endmodule

bind psrc_top psrc_top_properties #(.ADDR_W(ADDR_W)) u_chk (.*);
